/* verilog/cwc_mode_wake.sv */
// CAN transceiver mode control, wake detection and dominant time-outs.
// Assumes chip power mode requests and SPI writes arrive as one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none

module cwc_mode_wake
    import cwc_pkg::*;
#(
    parameter int ENABLE_CYC  = ENABLE_DELAY_CYC,
    parameter int WMIN_CYC    = WAKE_MIN_CYC,
    parameter int WMAX_CYC    = WAKE_MAX_CYC,
    parameter int TXTO_CYC    = TX_TIMEOUT_CYC,
    parameter int BUSTO_CYC   = BUS_TIMEOUT_CYC
)(
    input  wire logic        mclk,              // Device clock
    input  wire logic        nrst,              // Sync reset, active low
    input  wire logic        modeWrite,         // Strobe: write transceiver mode
    input  wire logic [1:0]  modeWriteData,     // Requested transceiver mode
    input  wire logic        chipModeWrite,     // Strobe: chip power mode change
    input  wire cwc_chip_t   chipModeData,      // Requested chip power mode
    input  wire logic        watchdogOnBusWake, // Enable watchdog on bus wake
    input  wire logic        watchdogDisable,   // Strobe: software disables watchdog
    input  wire logic        wakeFlagClear,     // Strobe: clear bus wake flag
    input  wire logic        faultClear,        // Strobe: clear bus fault flag
    input  wire logic        txLine,            // From controller, low is dominant
    input  wire logic        busDominant,       // Receiver comparator output
    output logic             rxLine,            // To controller, low is dominant
    output logic             busDrive,          // Drive dominant onto bus
    output logic             transmitterReady,  // Enabling delay elapsed
    output logic [1:0]       transceiverMode,   // Mode field readback
    output cwc_chip_t        chipMode,          // Present chip power mode
    output logic             intLowN,           // Interrupt, active low
    output cwc_status_t      status             // Flags
);

    // *****************************************************************
    // Elaboration checks
    // *****************************************************************
    if (WMIN_CYC < 1 || WMAX_CYC <= WMIN_CYC || WMAX_CYC >= (1 << CNT_W) ||
        ENABLE_CYC < 1 || ENABLE_CYC >= (1 << CNT_W) ||
        TXTO_CYC >= (1 << CNT_W) || BUSTO_CYC >= (1 << CNT_W))
    begin : g_bad
        $error("cwc_mode_wake: timing parameters out of range");
    end

    localparam logic [CNT_W-1:0] EN_C   = CNT_W'(ENABLE_CYC);
    localparam logic [CNT_W-1:0] WMIN_C = CNT_W'(WMIN_CYC);
    localparam logic [CNT_W-1:0] WMAX_C = CNT_W'(WMAX_CYC);
    localparam logic [CNT_W-1:0] TXTO_C = CNT_W'(TXTO_CYC);
    localparam logic [CNT_W-1:0] BUTO_C = CNT_W'(BUSTO_CYC);
    localparam logic [CNT_W-1:0] ONE_C  = CNT_W'(1);

    cwc_state_t s_q;
    cwc_state_t s_d;

    // *****************************************************************
    // Next state
    // *****************************************************************
    // Mode changes, wake detection and time-outs share one process so
    // that a mode change and a wake in the same cycle resolve one way.
    always_comb
    begin
        logic       modeChanged;
        logic       rearm;
        logic       wakeHit;
        logic       phaseOk;
        logic       driveOn;
        logic [1:0] req;
        s_d         = s_q;
        modeChanged = 1'b0;
        rearm       = 1'b0;
        wakeHit     = 1'b0;
        driveOn     = 1'b0;
        req         = modeWriteData;
        phaseOk     = (s_q.wkCnt > WMIN_C) && (s_q.wkCnt < WMAX_C);

        // Chip power mode; Fail-Safe forces wake-capable
        if (chipModeWrite)
        begin
            if (chipModeData == CHIP_STOP || chipModeData == CHIP_FAILSAFE)
                rearm = 1'b1;
            s_d.chip = chipModeData;
            if (chipModeData == CHIP_FAILSAFE && s_q.mode != TRX_WAKE)
            begin
                s_d.mode    = TRX_WAKE;
                modeChanged = 1'b1;
            end
        end

        // Mode write, gated by the chip power mode
        if (modeWrite && req != s_q.mode)
        begin
            unique case (req)
                TRX_OFF:
                begin
                    s_d.mode    = req;
                    modeChanged = 1'b1;
                end
                TRX_WAKE:
                    if (s_q.chip != CHIP_FAILSAFE)
                    begin
                        s_d.mode    = req;
                        modeChanged = 1'b1;
                    end
                TRX_RXONLY:
                    if (s_q.chip == CHIP_NORMAL || s_q.chip == CHIP_STOP)
                    begin
                        s_d.mode    = req;
                        modeChanged = 1'b1;
                    end
                TRX_NORMAL:
                    if (s_q.chip == CHIP_NORMAL)
                    begin
                        s_d.mode    = req;
                        modeChanged = 1'b1;
                    end
            endcase
        end

        // Leaving or toggling the mode clears the wake latch and flag
        if (modeChanged || rearm)
        begin
            s_d.wakeLatched    = 1'b0;
            s_d.st.busWakeFlag = 1'b0;
            s_d.wk             = WK_IDLE;
            s_d.wkCnt          = '0;
        end

        // Wake pattern filter: dominant, recessive, dominant
        if (s_q.mode == TRX_WAKE && !s_q.wakeLatched && !s_q.st.busWakeFlag)
        begin
            s_d.wkCnt = (s_q.wkCnt == WMAX_C) ? s_q.wkCnt : s_q.wkCnt + ONE_C;
            unique case (s_q.wk)
                WK_IDLE:
                    if (busDominant)
                    begin
                        s_d.wk    = WK_DOM1;
                        s_d.wkCnt = ONE_C;
                    end
                WK_DOM1:
                    if (!busDominant)
                    begin
                        s_d.wk    = phaseOk ? WK_REC : WK_IDLE;
                        s_d.wkCnt = ONE_C;
                    end
                WK_REC:
                    if (busDominant)
                    begin
                        s_d.wk    = phaseOk ? WK_DOM2 : WK_DOM1;
                        s_d.wkCnt = ONE_C;
                    end
                    else if (s_q.wkCnt == WMAX_C)
                        s_d.wk = WK_IDLE;
                WK_DOM2:
                    if (!busDominant)
                    begin
                        wakeHit   = phaseOk;
                        s_d.wk    = WK_IDLE;
                        s_d.wkCnt = '0;
                    end
            endcase
            // Off mode never reaches here, so wakes there are ignored
            if (modeChanged || rearm)
                wakeHit = 1'b0;
        end
        else if (!(modeChanged || rearm))
        begin
            s_d.wk    = WK_IDLE;
            s_d.wkCnt = '0;
        end

        // Wake effects per chip power mode; mode field stays wake-capable
        if (wakeHit)
        begin
            s_d.wakeLatched         = 1'b1;
            s_d.st.busWakeFlag      = 1'b1;
            s_d.st.wakeSourceStatus = 1'b1;
            unique case (s_q.chip)
                CHIP_NORMAL:
                    s_d.intLow = 1'b1;
                CHIP_STOP:
                begin
                    s_d.intLow = 1'b1;
                    if (watchdogOnBusWake)
                        s_d.st.watchdogEnable = 1'b1;
                end
                CHIP_SLEEP,
                CHIP_FAILSAFE:
                    s_d.chip = CHIP_RESTART;
                CHIP_RESTART:
                    s_d.chip = CHIP_NORMAL;
            endcase
        end
        else if (s_q.chip == CHIP_RESTART && s_q.wakeLatched && !chipModeWrite)
            s_d.chip = CHIP_NORMAL;

        if (wakeFlagClear && !wakeHit)
        begin
            s_d.st.busWakeFlag      = 1'b0;
            s_d.st.wakeSourceStatus = 1'b0;
            s_d.intLow              = 1'b0;
        end
        if (watchdogDisable && !wakeHit)
            s_d.st.watchdogEnable = 1'b0;

        // Enabling delay restarts on each entry to Normal
        if (s_d.mode != TRX_NORMAL)
        begin
            s_d.enCnt   = '0;
            s_d.enDone  = 1'b0;
            s_d.txArmed = 1'b0;
        end
        else if (!s_q.enDone)
        begin
            s_d.enCnt  = s_q.enCnt + ONE_C;
            s_d.enDone = (s_q.enCnt + ONE_C >= EN_C);
        end
        else if (txLine)
            s_d.txArmed = 1'b1;

        // Transmit dominant time-out; mode bits are left alone
        if (s_q.mode == TRX_NORMAL && !txLine)
        begin
            if (s_q.txCnt < TXTO_C)
                s_d.txCnt = s_q.txCnt + ONE_C;
            else
                s_d.st.txTimedOut = 1'b1;
        end
        else
        begin
            s_d.txCnt         = '0;
            s_d.st.txTimedOut = 1'b0;
        end

        // Bus dominant clamp
        if ((s_q.mode == TRX_NORMAL || s_q.mode == TRX_RXONLY) && busDominant)
        begin
            if (s_q.busCnt < BUTO_C)
                s_d.busCnt = s_q.busCnt + ONE_C;
        end
        else
            s_d.busCnt = '0;

        // Bus fault: set wins over clear
        if (faultClear)
            s_d.st.busFault = 1'b0;
        if ((s_q.mode == TRX_NORMAL && !txLine && s_q.txCnt >= TXTO_C) ||
            ((s_q.mode == TRX_NORMAL || s_q.mode == TRX_RXONLY) && busDominant &&
             s_q.busCnt >= BUTO_C))
            s_d.st.busFault = 1'b1;

        // Driver: Normal only, delay over, armed, no time-out
        // Next mode is used so that leaving Normal drops the driver at once
        driveOn = (s_d.mode == TRX_NORMAL) && s_q.enDone && s_q.txArmed;
        s_d.busDrive = driveOn && !txLine && !s_d.st.txTimedOut;

        // Receive line: bus level in Normal or receive-only, low while a wake is latched, else high
        if (s_d.wakeLatched)
            s_d.rxLine = 1'b0;
        else if (s_d.mode == TRX_NORMAL || s_d.mode == TRX_RXONLY)
            s_d.rxLine = !busDominant;
        else
            s_d.rxLine = 1'b1;
    end

    // *****************************************************************
    // State register
    // *****************************************************************
    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            s_q        <= '0;
            s_q.mode   <= TRX_OFF;
            s_q.chip   <= CHIP_NORMAL;
            s_q.wk     <= WK_IDLE;
            s_q.rxLine <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    // Outputs straight from flip-flops
    assign rxLine           = s_q.rxLine;
    assign busDrive         = s_q.busDrive;
    assign transmitterReady = s_q.enDone;
    assign transceiverMode  = s_q.mode;
    assign chipMode         = s_q.chip;
    assign intLowN          = !s_q.intLow;
    assign status           = s_q.st;

endmodule : cwc_mode_wake // cwc_mode_wake

`default_nettype wire

/* verilog/cwc_pkg.sv */
// Constants and carrier types for the CAN transceiver mode and wake control.
// Assumes one 100 MHz device clock and that all inputs are synchronous to it.
// Function
// - No dominant during enabling; afterwards only a dominant after recessive goes out.
// - In Normal and receive-only the receive line follows the bus: low dominant, high recessive.
// - Receive-only disables the driver; it can be selected only in Normal or Stop.
// - Wake-capable selectable in Stop, Sleep, Restart, Normal; forced in Fail-Safe.
// - A detected wake pattern holds the receive line low until the mode changes or Stop or Fail-Safe is commanded.
// - Wake pattern: dominant, recessive, dominant phases, each between the filter limits.
// - After a bus wake the mode field still reads the wake-capable code.
// - Entering Stop or Fail-Safe, or Stop commanded again, rearms detection.
// - The bus wake flag is cleared before rearming; a mode toggle clears it.
// - Wake in Stop or Normal: interrupt low, bus source recorded, receive line low.
// - A bus wake in Stop keeps the chip in Stop.
// - Bus wake in Stop enables the watchdog if watchdog-on-bus-wake was set.
// - Wake in Sleep goes to Restart then Normal, no interrupt, source recorded.
// - Transmit dominant too long in Normal forces recessive and sets bus fault.
// - Transmitter returns by itself once the transmit line is recessive again.
// - Bus dominant too long in Normal or receive-only sets bus fault.
// - Mode starts Off; in Off all bus wake activity is ignored.
// - Transceiver Normal mode is granted only in chip Normal mode.
package cwc_pkg;

    // *****************************************************************
    // Timing
    // *****************************************************************
    localparam int CLK_MHZ           = 100;
    localparam int ENABLE_DELAY_US   = 10;
    localparam int WAKE_MIN_NS       = 500;
    localparam int WAKE_MAX_US       = 1800;
    localparam int TX_TIMEOUT_US     = 2700;
    localparam int BUS_TIMEOUT_US    = 2700;
    localparam int ENABLE_DELAY_CYC  = ENABLE_DELAY_US * CLK_MHZ;
    localparam int WAKE_MIN_CYC      = (WAKE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_MAX_CYC      = WAKE_MAX_US * CLK_MHZ;
    localparam int TX_TIMEOUT_CYC    = TX_TIMEOUT_US * CLK_MHZ;
    localparam int BUS_TIMEOUT_CYC   = BUS_TIMEOUT_US * CLK_MHZ;
    localparam int CNT_W             = 20;

    // *****************************************************************
    // Mode codes
    // *****************************************************************
    localparam logic [1:0] TRX_OFF    = 2'h0;
    localparam logic [1:0] TRX_WAKE   = 2'h1;
    localparam logic [1:0] TRX_RXONLY = 2'h2;
    localparam logic [1:0] TRX_NORMAL = 2'h3;

    typedef enum logic [2:0] {
        CHIP_NORMAL,
        CHIP_STOP,
        CHIP_SLEEP,
        CHIP_RESTART,
        CHIP_FAILSAFE
    } cwc_chip_t;

    typedef enum logic [1:0] {
        WK_IDLE,
        WK_DOM1,
        WK_REC,
        WK_DOM2
    } cwc_wake_t;

    // Status carried out of the block
    typedef struct packed {
        logic       busWakeFlag;
        logic       wakeSourceStatus;
        logic       busFault;
        logic       txTimedOut;
        logic       watchdogEnable;
    } cwc_status_t;

    // All state of the block
    typedef struct packed {
        logic [1:0]        mode;
        cwc_chip_t         chip;
        logic [CNT_W-1:0]  enCnt;
        logic              enDone;
        logic              txArmed;
        logic [CNT_W-1:0]  txCnt;
        logic [CNT_W-1:0]  busCnt;
        cwc_wake_t         wk;
        logic [CNT_W-1:0]  wkCnt;
        logic              wakeLatched;
        logic              intLow;
        logic              rxLine;
        logic              busDrive;
        cwc_status_t       st;
    } cwc_state_t;

endpackage : cwc_pkg

/* verif/cwc_mode_wake_asserts.sv */
// Concurrent checks on the ports of the mode and wake control.
// Bound to cwc_mode_wake from the testbench top file; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module cwc_mode_wake_asserts
    import cwc_pkg::*;
#(
    parameter int TXTO_CYC  = TX_TIMEOUT_CYC,
    parameter int BUSTO_CYC = BUS_TIMEOUT_CYC
)(
    input wire logic        mclk,              // Device clock
    input wire logic        nrst,              // Sync reset, active low
    input wire logic        modeWrite,         // Mode strobe
    input wire logic [1:0]  modeWriteData,     // Mode asked for
    input wire logic        chipModeWrite,     // Chip mode strobe
    input wire logic        watchdogOnBusWake, // Watchdog config
    input wire logic        txLine,            // Transmit line
    input wire logic        busDominant,       // Bus level
    input wire logic        rxLine,            // Receive line
    input wire logic        busDrive,          // Driver on
    input wire logic        transmitterReady,  // Enabling over
    input wire logic [1:0]  transceiverMode,   // Mode readback
    input wire cwc_chip_t   chipMode,          // Chip mode
    input wire logic        intLowN,           // Interrupt
    input wire cwc_status_t status             // Flags
);
    logic [CNT_W-1:0] txCnt_q;  // Dominant transmit run in Normal
    logic [CNT_W-1:0] busCnt_q; // Dominant bus run while listening
    wire logic        listen = transceiverMode == TRX_NORMAL || transceiverMode == TRX_RXONLY;

    // Run lengths; a small slack keeps the figures free of edge ambiguity
    always_ff @(posedge mclk)
    begin
        txCnt_q  <= (!nrst || txLine || transceiverMode != TRX_NORMAL) ? '0 : txCnt_q + 1'b1;
        busCnt_q <= (!nrst || !busDominant || !listen) ? '0 : busCnt_q + 1'b1;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // Sleep wake: restart first, normal one cycle later, interrupt quiet
    sequence restartThenNormal;
        !rxLine && chipMode == CHIP_RESTART && intLowN ##1 chipMode == CHIP_NORMAL && intLowN;
    endsequence

    a_reset_state: assert property ($rose(nrst) |-> transceiverMode == TRX_OFF && rxLine && !busDrive)
        else $error("State after reset wrong");
    a_drive_cause: assert property (busDrive |-> !$past(txLine) && transmitterReady)
        else $error("Dominant driven without cause");
    a_rx_follow: assert property (listen && $past(listen) |-> rxLine == !$past(busDominant))
        else $error("Receive line not following bus");
    a_rxonly_idle: assert property ($past(transceiverMode) == TRX_RXONLY &&
        transceiverMode == TRX_RXONLY |-> !busDrive)
        else $error("Driver active in receive-only");
    a_mode_gate: assert property (modeWrite && !chipModeWrite && chipMode != CHIP_NORMAL &&
        (modeWriteData == TRX_NORMAL || modeWriteData == TRX_RXONLY && chipMode != CHIP_STOP)
        |=> $stable(transceiverMode))
        else $error("Mode granted in wrong chip mode");
    a_wake_hold: assert property (status.busWakeFlag && transceiverMode == TRX_WAKE &&
        !modeWrite && !chipModeWrite |=> !rxLine)
        else $error("Receive line released while woken");
    a_stop_wake: assert property ($rose(status.busWakeFlag) && $past(chipMode) == CHIP_STOP |->
        chipMode == CHIP_STOP && !intLowN && !rxLine && status.wakeSourceStatus
        && status.watchdogEnable == ($past(watchdogOnBusWake) || $past(status.watchdogEnable)))
        else $error("Stop wake handled wrong");
    a_sleep_wake: assert property ($rose(status.busWakeFlag) && $past(chipMode) == CHIP_SLEEP |->
        restartThenNormal)
        else $error("Sleep wake handled wrong");
    a_tx_timeout: assert property (txCnt_q > TXTO_CYC + 2 |->
        status.txTimedOut && status.busFault && !busDrive)
        else $error("Transmit time-out missed");
    a_tx_recover: assert property (status.txTimedOut && txLine |=> !status.txTimedOut)
        else $error("Transmitter not recovered");
    a_bus_clamp: assert property (busCnt_q > BUSTO_CYC + 2 |-> status.busFault)
        else $error("Bus clamp missed");
endmodule // cwc_mode_wake_asserts
`default_nettype wire

/* verif/cwc_mcu_model.sv */
// Behavioural model of the microcontroller's CAN protocol controller.
// Clocked by the device clock; the bench says when dominant is wanted.
`timescale 1ns/1ps
`default_nettype none

module cwc_mcu_model (
    input  wire logic mclk,             // Device clock
    input  wire logic transmitterReady, // Enabling delay over
    input  wire logic txWant,           // Bench asks for dominant
    input  wire logic early,            // Misbehave: ignore the delay
    output var logic  txLine            // To the device, low dominant
);
    // Recessive until ready, unless a scenario asks for an early dominant
    // One process owns the line, so it has a single driver
    initial
    begin
        txLine = 1'b1;
        forever
        begin
            @(posedge mclk);
            txLine <= (transmitterReady || early) ? !txWant : 1'b1;
        end
    end
endmodule // cwc_mcu_model
`default_nettype wire

/* verif/tb_can_transceiver_mode_wake_control.sv */
// Self-checking bench for the transceiver mode and wake control.
// Drives inputs 1 ns after each edge; a monitor checks queued notes.
`timescale 1ns/1ps
`default_nettype none

module tb_can_transceiver_mode_wake_control
    import cwc_pkg::*;
;
    localparam int ENC = 4;
    localparam int WMN = 3;
    localparam int WMX = 10;
    localparam int TXT = 20;
    localparam int BST = 20;
    typedef struct {int id; logic [7:0] v;} cwc_note_t;

    logic        mclk, nrst, modeWrite, chipModeWrite, wdOnWake, wdDis, wfClr, fClr;
    logic        txLine, busExt, txWant, early, rxLine, busDrive, ready, intLowN;
    logic [1:0]  modeData, trxMode;
    cwc_chip_t   chipData, chipMode;
    cwc_status_t status;
    logic [15:0] lfsr;
    int          err_count, checks_done;
    cwc_note_t   notes[$];
    cwc_note_t   n;
    event        noteEv;
    string       nm[8] = '{"rxLine", "busDrive", "ready", "mode", "chipMode", "intLowN", "status", "wakeFlag"};
    wire logic   busDom = busDrive | busExt; // Wired bus: either side pulls dominant
    wire logic [63:0] obsAll = {7'h0, status.busWakeFlag, 3'h0, status, 7'h0, intLowN, 5'h0, chipMode,
                                6'h0, trxMode, 7'h0, ready, 7'h0, busDrive, 7'h0, rxLine};

    cwc_mode_wake #(.ENABLE_CYC(ENC), .WMIN_CYC(WMN), .WMAX_CYC(WMX), .TXTO_CYC(TXT), .BUSTO_CYC(BST)) dut (
        .mclk(mclk), .nrst(nrst), .modeWrite(modeWrite), .modeWriteData(modeData),
        .chipModeWrite(chipModeWrite), .chipModeData(chipData), .watchdogOnBusWake(wdOnWake),
        .watchdogDisable(wdDis), .wakeFlagClear(wfClr), .faultClear(fClr), .txLine(txLine),
        .busDominant(busDom), .rxLine(rxLine), .busDrive(busDrive), .transmitterReady(ready),
        .transceiverMode(trxMode), .chipMode(chipMode), .intLowN(intLowN), .status(status));
    cwc_mcu_model mcu (.mclk(mclk), .transmitterReady(ready), .txWant(txWant), .early(early), .txLine(txLine));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic tick(int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic chk(int id, logic [7:0] v);
        notes.push_back('{id, v});
        ->noteEv;
    endtask
    task automatic setMode(logic [1:0] m);
        modeWrite = 1'b1;
        modeData = m;
        tick(1);
        modeWrite = 1'b0;
        // Spare edge: a following call never lowers and raises a strobe at once
        tick(1);
    endtask
    task automatic setChip(cwc_chip_t c);
        chipModeWrite = 1'b1;
        chipData = c;
        tick(1);
        chipModeWrite = 1'b0;
        tick(1);
    endtask
    task automatic clears(logic w, logic f, logic d);
        {wfClr, fClr, wdDis} = {w, f, d};
        tick(1);
        {wfClr, fClr, wdDis} = 3'h0;
        tick(1);
    endtask
    // Dominant, recessive, dominant, then a recessive idle longer than the filter
    task automatic wake_pattern(int a, int b, int c);
        busExt = 1'b1;
        tick(a);
        busExt = 1'b0;
        tick(b);
        busExt = 1'b1;
        tick(c);
        busExt = 1'b0;
        tick(WMX + 2);
    endtask
    // Phase lengths kept strictly inside the filter window
    function automatic int rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return 4 + int'(lfsr % 6);
    endfunction
    task automatic end_sim();
        $display("Checks %0d, errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Monitor: oldest note first, against the output it names
    always @(noteEv)
    begin
        while (notes.size() > 0)
        begin
            n = notes.pop_front();
            checks_done++;
            if (obsAll[n.id*8 +: 8] !== n.v)
            begin
                err_count++;
                $display("[ERR] %s expected %h seen %h", nm[n.id], n.v, obsAll[n.id*8 +: 8]);
            end
        end
    end

    // Clock and hang guard
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        #50000;
        err_count++;
        end_sim();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        {nrst, modeWrite, chipModeWrite, wdOnWake, wdDis, wfClr, fClr, busExt, txWant, early} = '0;
        modeData = TRX_OFF;
        chipData = CHIP_NORMAL;
        lfsr = 16'hC069;
        err_count = 0;
        checks_done = 0;
        tick(4);
        nrst = 1'b1;
        chk(3, TRX_OFF);
        chk(0, 8'h01);
        chk(6, 8'h00);
        wake_pattern(5, 5, 5);
        chk(7, 8'h00);
        // Refused and granted mode requests
        setChip(CHIP_SLEEP);
        setMode(TRX_RXONLY);
        chk(3, TRX_OFF);
        setChip(CHIP_STOP);
        setMode(TRX_NORMAL);
        chk(3, TRX_OFF);
        setMode(TRX_RXONLY);
        chk(3, TRX_RXONLY);
        busExt = 1'b1;
        tick(3);
        chk(0, 8'h00);
        chk(1, 8'h00);
        tick(BST + 2);
        chk(6, 8'h04);
        chk(3, TRX_RXONLY);
        busExt = 1'b0;
        clears(0, 1, 0);
        // Early dominant is held off, then random traffic
        setChip(CHIP_NORMAL);
        setMode(TRX_NORMAL);
        chk(3, TRX_NORMAL);
        {early, txWant} = 2'h3;
        tick(ENC + 4);
        chk(2, 8'h01);
        chk(1, 8'h00);
        {early, txWant} = 2'h0;
        tick(2);
        repeat (8)
        begin
            void'(rnd());
            txWant = lfsr[3];
            tick(2);
            chk(1, {7'h0, txWant});
        end
        // Stuck dominant transmit
        txWant = 1'b1;
        tick(TXT + 5);
        chk(6, 8'h06);
        chk(1, 8'h00);
        chk(3, TRX_NORMAL);
        txWant = 1'b0;
        tick(3);
        chk(6, 8'h04);
        txWant = 1'b1;
        tick(2);
        chk(1, 8'h01);
        txWant = 1'b0;
        clears(0, 1, 0);
        // Wakes in chip Normal, Stop, Sleep and Fail-Safe, rearm paths, near misses
        setMode(TRX_WAKE);
        wake_pattern(rnd(), rnd(), rnd());
        chk(0, 8'h00);
        chk(5, 8'h00);
        chk(6, 8'h18);
        chk(3, TRX_WAKE);
        setMode(TRX_OFF);
        setMode(TRX_WAKE);
        chk(7, 8'h00);
        clears(1, 0, 0);
        setChip(CHIP_STOP);
        wdOnWake = 1'b1;
        wake_pattern(rnd(), rnd(), rnd());
        chk(4, CHIP_STOP);
        chk(6, 8'h19);
        setChip(CHIP_STOP);
        chk(7, 8'h00);
        clears(1, 0, 1);
        chk(6, 8'h00);
        wake_pattern(WMN, 5, 5);
        wake_pattern(5, WMX, 5);
        chk(7, 8'h00);
        setChip(CHIP_SLEEP);
        wake_pattern(rnd(), rnd(), rnd());
        chk(4, CHIP_NORMAL);
        chk(5, 8'h01);
        chk(0, 8'h00);
        setMode(TRX_OFF);
        setChip(CHIP_FAILSAFE);
        chk(3, TRX_WAKE);
        wake_pattern(rnd(), rnd(), rnd());
        chk(4, CHIP_NORMAL);
        chk(5, 8'h01);
        // Transmitter supply is taken as switched on before leaving wake-capable
        setMode(TRX_NORMAL);
        chk(0, 8'h01);
        chk(3, TRX_NORMAL);
        tick(2);
        end_sim();
    end
endmodule // tb_can_transceiver_mode_wake_control

bind cwc_mode_wake cwc_mode_wake_asserts #(.TXTO_CYC(TXTO_CYC), .BUSTO_CYC(BUSTO_CYC)) u_asserts (.*);
`default_nettype wire
